// ==== core/lcp_channel_regs.sv ====
// lcp_channel_regs: per-channel packet settings, retransmission counters,
// error output and interrupt, reached over Avalon-MM.
// assumes: one clock, datapath events synchronous to it, strap sampled here.
//
// Summary of operation
// [RQ1] transmit CRC enable per channel steers datapath
// [RQ2] receive CRC enable requests checking every packet
// [RQ3] two-bit stream id inserted, resets to 10
// [RQ4] three-bit source id placed in packets
// [RQ5] source id reset taken from address strap
// [RQ6] one-hot source mask filters received packets
// [RQ7] retry protocol enable bit 3, reset on
// [RQ8] bit 2 suppresses duplicate-ack retransmission
// [RQ9] limit reached drives error pin when enabled
// [RQ10] nonzero count drives error pin when enabled
// [RQ11] limit flag bit 7, cleared on read
// [RQ12] seven-bit retry count, cleared on read
// [RQ13] retry count saturates instead of wrapping
`timescale 1ns/100ps
`default_nettype none
module lcp_channel_regs
    import lcp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic address_strap_pin_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire lcp_chan_evt_type [LCP_NCH-1:0] chan_evt_i,
    output lcp_chan_cfg_type [LCP_NCH-1:0] chan_cfg_o,
    output lcp_chan_ans_type [LCP_NCH-1:0] chan_ans_o,
    output logic error_out_n_o,
    output logic irq_o
);

    // registers
    logic [1:0] stream_q;
    logic [7:0] crc_q [LCP_NCH];
    logic [2:0] src_q [LCP_NCH];
    logic [7:0] filt_q [LCP_NCH];
    logic [7:0] rctl_q [LCP_NCH];
    logic [7:0] rrep_q [LCP_NCH];
    logic [LCP_NCH-1:0] lim_q;
    logic [6:0] cnt_q [LCP_NCH];
    logic [7:0] irq_st_q;
    logic [7:0] irq_mask_q;
    logic [2:0] strap_sync_q;
    logic [1:0] fill_q;
    logic strap_seen_q;
    logic ack_q;

    // bus decode
    logic wr_en;
    logic rd_en;
    logic [LCP_NCH-1:0] st_rd;
    always_comb begin
        wr_en = avs_write_i && !ack_q && avs_byteenable_i[0];
        rd_en = avs_read_i && !ack_q;
        for (int c = 0; c < LCP_NCH; c++) begin
            st_rd[c] = rd_en && (avs_address_i == OFS_RETRY_STATUS[c]);
        end
    end

    // one-cycle wait then acknowledge
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= (avs_read_i || avs_write_i) && !ack_q;
        end
    end

    // strap synchroniser: second and third stage agree
    // fill_q keeps the reset zeros in the chain from passing as an agreed level
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            strap_sync_q <= 3'b000;
            fill_q <= 2'b00;
        end else if (ce_i) begin
            strap_sync_q <= {strap_sync_q[1:0], address_strap_pin_i};
            if (fill_q != 2'b11) begin
                fill_q <= fill_q + 2'b01;
            end
        end
    end

    // stream id register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            // [RQ3] stream id reset
            stream_q <= RST_STREAM_SELECT[1:0];
        end else if (ce_i && wr_en && avs_address_i == OFS_STREAM_SELECT_5B) begin
            stream_q <= avs_writedata_i[1:0];
        end
    end

    // per-channel configuration registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            strap_seen_q <= 1'b0;
            for (int c = 0; c < LCP_NCH; c++) begin
                crc_q[c] <= RST_CRC_CTRL;
                src_q[c] <= 3'b000;
                filt_q[c] <= RST_SOURCE_FILTER;
                rctl_q[c] <= RST_RETRY_CTRL;
                rrep_q[c] <= RST_RETRY_REPORT;
            end
        end else if (ce_i) begin
            // [RQ5] strap loads source id
            if (!strap_seen_q && fill_q == 2'b11 && strap_sync_q[2] == strap_sync_q[1]) begin
                strap_seen_q <= 1'b1;
                for (int c = 0; c < LCP_NCH; c++) begin
                    src_q[c] <= {2'b00, strap_sync_q[2]};
                end
            end
            for (int c = 0; c < LCP_NCH; c++) begin
                if (wr_en && avs_address_i == OFS_CRC_CTRL[c]) begin
                    crc_q[c][7:6] <= avs_writedata_i[7:6];
                end
                if (wr_en && avs_address_i == OFS_SOURCE_ID[c]) begin
                    src_q[c] <= avs_writedata_i[2:0];
                end
                if (wr_en && avs_address_i == OFS_SOURCE_FILTER[c]) begin
                    filt_q[c] <= avs_writedata_i[7:0];
                end
                if (wr_en && avs_address_i == OFS_RETRY_CTRL[c]) begin
                    rctl_q[c][3:2] <= avs_writedata_i[3:2];
                end
                if (wr_en && avs_address_i == OFS_RETRY_REPORT[c]) begin
                    rrep_q[c][1:0] <= avs_writedata_i[1:0];
                end
            end
        end
    end

    // retransmission status: set wins over read-clear
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            lim_q <= '0;
            for (int c = 0; c < LCP_NCH; c++) begin
                cnt_q[c] <= RST_RETRY_STATUS[6:0];
            end
        end else if (ce_i) begin
            for (int c = 0; c < LCP_NCH; c++) begin
                // [RQ11] limit flag sticky
                if (chan_evt_i[c].limit_hit) begin
                    lim_q[c] <= 1'b1;
                end else if (st_rd[c]) begin
                    lim_q[c] <= 1'b0;
                end
                // [RQ12] [RQ13] saturating count
                if (chan_evt_i[c].retry) begin
                    cnt_q[c] <= st_rd[c] ? 7'h01 :
                        (cnt_q[c] == CNT_MAX ? CNT_MAX : cnt_q[c] + 7'h01);
                end else if (st_rd[c]) begin
                    cnt_q[c] <= 7'h00;
                end
            end
        end
    end

    // interrupt status: bit c limit, bit 4+c retry
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            irq_st_q <= 8'h00;
            irq_mask_q <= RST_IRQ_MASK;
        end else if (ce_i) begin
            for (int c = 0; c < LCP_NCH; c++) begin
                irq_st_q[c] <= chan_evt_i[c].limit_hit ||
                    (irq_st_q[c] && !(wr_en && avs_address_i == OFS_IRQ_STATUS &&
                    avs_writedata_i[c]));
                irq_st_q[4+c] <= chan_evt_i[c].retry ||
                    (irq_st_q[4+c] && !(wr_en && avs_address_i == OFS_IRQ_STATUS &&
                    avs_writedata_i[4+c]));
            end
            if (wr_en && avs_address_i == OFS_IRQ_MASK) begin
                irq_mask_q <= avs_writedata_i[7:0];
            end
        end
    end

    // read data and outputs
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            avs_readdata_o <= 32'h0000_0000;
            avs_waitrequest_o <= 1'b1;
            error_out_n_o <= 1'b1;
            irq_o <= 1'b0;
            chan_cfg_o <= '0;
            chan_ans_o <= '0;
        end else if (ce_i) begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_q);
            if (rd_en) begin
                avs_readdata_o <= 32'h0000_0000;
                if (avs_address_i == OFS_STREAM_SELECT_5B) begin
                    avs_readdata_o[1:0] <= stream_q;
                end
                if (avs_address_i == OFS_IRQ_STATUS) begin
                    avs_readdata_o[7:0] <= irq_st_q;
                end
                if (avs_address_i == OFS_IRQ_MASK) begin
                    avs_readdata_o[7:0] <= irq_mask_q;
                end
                for (int c = 0; c < LCP_NCH; c++) begin
                    if (avs_address_i == OFS_CRC_CTRL[c]) begin
                        avs_readdata_o[7:0] <= crc_q[c];
                    end
                    if (avs_address_i == OFS_SOURCE_ID[c]) begin
                        avs_readdata_o[2:0] <= src_q[c];
                    end
                    if (avs_address_i == OFS_SOURCE_FILTER[c]) begin
                        avs_readdata_o[7:0] <= filt_q[c];
                    end
                    if (avs_address_i == OFS_RETRY_CTRL[c]) begin
                        avs_readdata_o[7:0] <= rctl_q[c];
                    end
                    if (avs_address_i == OFS_RETRY_REPORT[c]) begin
                        avs_readdata_o[7:0] <= rrep_q[c];
                    end
                    if (st_rd[c]) begin
                        avs_readdata_o[7:0] <= {lim_q[c], cnt_q[c]};
                    end
                end
            end
            irq_o <= |(irq_st_q & irq_mask_q);
            // [RQ9] [RQ10] error pin active low
            error_out_n_o <= 1'b1;
            for (int c = 0; c < LCP_NCH; c++) begin
                if ((rrep_q[c][POS_LIMIT_REPORT] && lim_q[c]) ||
                    (rrep_q[c][POS_COUNT_REPORT] && cnt_q[c] != 7'h00)) begin
                    error_out_n_o <= 1'b0;
                end
                // [RQ1] [RQ2] crc enables
                chan_cfg_o[c].tx_crc_en <= crc_q[c][POS_TX_CRC];
                chan_cfg_o[c].rx_crc_en <= crc_q[c][POS_RX_CRC];
                // [RQ3] [RQ4] header ids
                chan_cfg_o[c].outgoing_stream_id <= stream_q;
                chan_cfg_o[c].outgoing_source_id <= src_q[c];
                chan_cfg_o[c].incoming_source_mask <= filt_q[c];
                // [RQ7] retry protocol enable
                chan_cfg_o[c].retry_protocol_enable <= rctl_q[c][POS_RETRY_EN];
                chan_cfg_o[c].duplicate_ack_retry_off <= rctl_q[c][POS_DUP_ACK_OFF];
                // [RQ8] duplicate ack retransmit
                chan_ans_o[c].do_retry <= chan_evt_i[c].dup_ack &&
                    rctl_q[c][POS_RETRY_EN] && !rctl_q[c][POS_DUP_ACK_OFF];
                // [RQ6] one-hot source filter
                chan_ans_o[c].rx_accept <= chan_evt_i[c].rx_valid &&
                    mask_hit(filt_q[c], chan_evt_i[c].rx_source_id);
                // [RQ2] check crc on packet
                chan_ans_o[c].rx_crc_check <= chan_evt_i[c].rx_valid &&
                    crc_q[c][POS_RX_CRC];
            end
        end
    end

endmodule
`default_nettype wire

// ==== core/lcp_pkg.sv ====
// lcp_pkg: register map, field positions, reset values and carrier types
// for the per-channel packet settings block; the only logic here is the mask_hit lookup.
package lcp_pkg;

    localparam int LCP_NCH = 4;

    // byte offsets of the registers (compared with the bus address directly; 8'h94 and 8'h95 each select two channels)
    localparam logic [7:0] OFS_STREAM_SELECT_5B = 8'h5b;
    localparam logic [7:0] OFS_CRC_CTRL_78 = 8'h78;
    localparam logic [7:0] OFS_SOURCE_ID_7B = 8'h7b;
    localparam logic [7:0] OFS_SOURCE_FILTER_7C = 8'h7c;
    // per-channel register groups for channels 0..3
    localparam logic [7:0] OFS_CRC_CTRL [LCP_NCH] = '{8'h80, 8'h88, 8'h90, 8'ha0};
    localparam logic [7:0] OFS_SOURCE_ID [LCP_NCH] = '{8'h83, 8'h8b, 8'h93, 8'ha3};
    localparam logic [7:0] OFS_SOURCE_FILTER [LCP_NCH] = '{8'h84, 8'h94, 8'h94, 8'ha4};
    localparam logic [7:0] OFS_RETRY_CTRL [LCP_NCH] = '{8'h85, 8'h95, 8'h95, 8'ha5};
    localparam logic [7:0] OFS_RETRY_REPORT [LCP_NCH] = '{8'h86, 8'h8e, 8'h96, 8'ha6};
    localparam logic [7:0] OFS_RETRY_STATUS [LCP_NCH] = '{8'h87, 8'h8f, 8'h97, 8'ha7};
    localparam logic [7:0] OFS_CRC_CTRL_A8 = 8'ha8;
    localparam logic [7:0] OFS_SOURCE_ID_AB = 8'hab;
    localparam logic [7:0] OFS_SOURCE_FILTER_AC = 8'hac;
    localparam logic [7:0] OFS_RETRY_CTRL_AD = 8'had;
    localparam logic [7:0] OFS_RETRY_REPORT_AE = 8'hae;
    localparam logic [7:0] OFS_RETRY_STATUS_AF = 8'haf;
    // own registers: interrupt status and mask
    localparam logic [7:0] OFS_IRQ_STATUS = 8'hc0;
    localparam logic [7:0] OFS_IRQ_MASK = 8'hc1;

    // field positions
    localparam int POS_TX_CRC = 7;
    localparam int POS_RX_CRC = 6;
    localparam int POS_RETRY_EN = 3;
    localparam int POS_DUP_ACK_OFF = 2;
    localparam int POS_LIMIT_REPORT = 1;
    localparam int POS_COUNT_REPORT = 0;
    localparam int POS_LIMIT_FLAG = 7;

    // reset values
    localparam logic [7:0] RST_STREAM_SELECT = 8'h02;
    localparam logic [7:0] RST_CRC_CTRL = 8'hf0;
    localparam logic [7:0] RST_SOURCE_FILTER = 8'hff;
    localparam logic [7:0] RST_RETRY_CTRL = 8'h98;
    localparam logic [7:0] RST_RETRY_REPORT = 8'h72;
    localparam logic [7:0] RST_RETRY_STATUS = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;
    localparam logic [6:0] CNT_MAX = 7'h7f;

    // per-channel settings toward the packet datapath
    typedef struct packed {
        logic tx_crc_en;
        logic rx_crc_en;
        logic [1:0] outgoing_stream_id;
        logic [2:0] outgoing_source_id;
        logic [7:0] incoming_source_mask;
        logic retry_protocol_enable;
        logic duplicate_ack_retry_off;
    } lcp_chan_cfg_type;

    // per-channel events from the retransmission engine
    typedef struct packed {
        logic retry;
        logic dup_ack;
        logic limit_hit;
        logic rx_valid;
        logic [2:0] rx_source_id;
    } lcp_chan_evt_type;

    // per-channel answers to the datapath
    typedef struct packed {
        logic do_retry;
        logic rx_accept;
        logic rx_crc_check;
    } lcp_chan_ans_type;

    // one-hot mask lookup
    function automatic logic mask_hit(input logic [7:0] mask, input logic [2:0] sid);
        mask_hit = mask[sid];
    endfunction

endpackage

// ==== testbench/lcp_chk.sv ====
// lcp_chk: port-level timing checks for lcp_channel_regs
// assumes: bound from tb, one clock, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module lcp_chk
    import lcp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic address_strap_pin_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire lcp_chan_evt_type [LCP_NCH-1:0] chan_evt_i,
    input wire lcp_chan_cfg_type [LCP_NCH-1:0] chan_cfg_o,
    input wire lcp_chan_ans_type [LCP_NCH-1:0] chan_ans_o,
    input wire logic error_out_n_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i || !ce_i);

    // bus handshake: reset level, answer delay, one-cycle answer
    a_wait_reset: assert property (disable iff (!ce_i)
        rst_i |=> avs_waitrequest_o && error_out_n_o && !irq_o)
        else $error("outputs not idle in reset");
    a_wait_answer: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
        else $error("request not answered next cycle");
    a_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low longer than one cycle");
    // per-packet answers of channel 0
    a_rx_filter: assert property (1'b1 |=> chan_ans_o[0].rx_accept == $past(chan_evt_i[0].rx_valid
        && chan_cfg_o[0].incoming_source_mask[chan_evt_i[0].rx_source_id]))
        else $error("source filter answer wrong");
    a_crc_check: assert property (1'b1 |=> chan_ans_o[0].rx_crc_check ==
        $past(chan_evt_i[0].rx_valid && chan_cfg_o[0].rx_crc_en))
        else $error("crc check request wrong");
    a_dup_retry: assert property (chan_evt_i[0].dup_ack && !chan_evt_i[0].retry |=>
        chan_ans_o[0].do_retry == !$past(chan_cfg_o[0].duplicate_ack_retry_off))
        else $error("duplicate ack retry wrong");
    // settings after reset release
    a_cfg_reset: assert property ($fell(rst_i) |=> chan_cfg_o[0].outgoing_stream_id == 2'b10
        && chan_cfg_o[0].tx_crc_en && chan_cfg_o[0].retry_protocol_enable)
        else $error("settings not at reset values");
    a_src_strap: assert property ($fell(rst_i) |-> ##6
        chan_cfg_o[0].outgoing_source_id == {2'b00, address_strap_pin_i})
        else $error("source id not from strap");
endmodule
`default_nettype wire

// ==== testbench/lcp_far_model.sv ====
// lcp_far_model: far-end retransmission engine and receiver, raises event pulses
// assumes: shares the bench clock, driven through its pulse task
`timescale 1ns/100ps
`default_nettype none
module lcp_far_model
    import lcp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire lcp_chan_cfg_type [LCP_NCH-1:0] cfg_i,
    output var lcp_chan_evt_type [LCP_NCH-1:0] evt_o
);
    initial evt_o = '0;
    // retry events dropped unless the retry protocol is enabled
    task automatic pulse(input int ch, input lcp_chan_evt_type e);
        if (!cfg_i[ch].retry_protocol_enable)
            e.retry = 1'b0;
        @(posedge clk_sys_i);
        evt_o[ch] <= e;
        @(posedge clk_sys_i);
        evt_o[ch] <= '0;
    endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// tb: self-checking bench for lcp_channel_regs over Avalon-MM
// assumes: lcp_chk and lcp_far_model compiled before this file
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module tb
    import lcp_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic wait_rq, err_n, irq, a;
    int errors = 0;
    int compares = 0;
    lcp_chan_evt_type [LCP_NCH-1:0] evt;
    lcp_chan_cfg_type [LCP_NCH-1:0] cfg;
    lcp_chan_ans_type [LCP_NCH-1:0] ans;

    lcp_channel_regs u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
        .address_strap_pin_i(1'b1), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_rq), .chan_evt_i(evt),
        .chan_cfg_o(cfg), .chan_ans_o(ans), .error_out_n_o(err_n), .irq_o(irq));
    lcp_far_model u_far (.clk_sys_i(clk_sys_i), .cfg_i(cfg), .evt_o(evt));

    // 100 MHz clock
    always #5 clk_sys_i = ~clk_sys_i;

    // one Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] d,
        output logic [7:0] q);
        int n;
        @(posedge clk_sys_i);
        rd <= !w;
        wr <= w;
        addr <= ad;
        wdata <= {24'h00_0000, d};
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (wait_rq !== 1'b0 && n < 50);
        q = rdata[7:0];
        if (n >= 50) `CHK(1'b0, 1'b1)
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, ad, d, q);
    endtask
    task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, ad, 8'h00, q);
        `CHK(q, e)
    endtask
    task automatic settle();
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic ev(input lcp_chan_evt_type e);
        u_far.pulse(0, e);
        #1;
    endtask

    task automatic t_reset();
        rchk(8'h5b, 8'h02);
        rchk(8'h80, 8'hf0);
        rchk(8'h83, 8'h01);
        rchk(8'h84, 8'hff);
        rchk(8'h85, 8'h98);
        rchk(8'h86, 8'h72);
        rchk(8'h87, 8'h00);
        wreg(8'h78, 8'h55);
        rchk(8'h78, 8'h00); // unmapped place stays zero
        $display("test reset done");
    endtask
    task automatic t_fields();
        wreg(8'h5b, 8'h01);
        wreg(8'h83, 8'h05);
        wreg(8'h80, 8'h40);
        settle();
        `CHK(cfg[0].outgoing_stream_id, 2'b01)
        `CHK(cfg[0].outgoing_source_id, 3'h5)
        `CHK({cfg[0].tx_crc_en, cfg[0].rx_crc_en}, 2'b01)
        $display("test fields done");
    endtask
    task automatic t_mask();
        wreg(8'h84, 8'h09);
        for (int m = 0; m < 2; m++) begin
            settle();
            for (int s = 0; s < 8; s++) begin
                ev({4'h1, s[2:0]});
                `CHK(ans[0].rx_accept, (m == 0) && (s == 0 || s == 3))
                `CHK(ans[0].rx_crc_check, 1'b1)
            end
            wreg(8'h84, 8'h00);
        end
        $display("test mask done");
    endtask
    task automatic t_dup();
        for (int k = 0; k < 2; k++) begin
            wreg(8'h85, k ? 8'h9c : 8'h98);
            settle();
            ev(7'h20);
            `CHK(ans[0].do_retry, !k[0])
        end
        $display("test dup ack done");
    endtask
    task automatic t_count();
        wreg(8'h86, 8'h73);
        repeat (3) ev(7'h40);
        settle();
        `CHK(err_n, 1'b0)
        rchk(8'h87, 8'h03);
        settle();
        `CHK(err_n, 1'b1)
        rchk(8'h87, 8'h00);
        repeat (130) ev(7'h40);
        rchk(8'h87, 8'h7f);
        wreg(8'h86, 8'h72);
        $display("test count done");
    endtask
    task automatic t_limit();
        wreg(8'hc0, 8'hff);
        ev(7'h10);
        settle();
        `CHK(err_n, 1'b0)
        wreg(8'hc1, 8'h00);
        settle();
        a = irq;
        wreg(8'hc1, 8'h01);
        settle();
        `CHK(a ^ irq, 1'b1) // mask bit decides the level
        rchk(8'h87, 8'h80);
        rchk(8'h87, 8'h00);
        settle();
        `CHK(err_n, 1'b1)
        wreg(8'hc0, 8'h01);
        settle();
        `CHK(irq, 1'b0) // write one clears status
        $display("test limit done");
    endtask
    task automatic t_freeze();
        @(posedge clk_sys_i);
        ce <= 1'b0;
        ev(7'h50);
        @(posedge clk_sys_i);
        ce <= 1'b1;
        settle();
        `CHK(irq, 1'b0) // frozen event leaves status clear
        rchk(8'h87, 8'h00);
        $display("test freeze done");
    endtask

    task automatic give_verdict();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // main sequence: 2-cycle reset, strap settle, then the tests
    initial begin
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        t_reset();
        t_fields();
        t_mask();
        t_dup();
        t_count();
        t_limit();
        t_freeze();
        give_verdict();
    end
    // watchdog: the run needs well under 2000 cycles
    initial begin
        #100000;
        errors++;
        give_verdict();
    end
endmodule
bind lcp_channel_regs lcp_chk u_chk (.clk_sys_i, .rst_i, .ce_i, .address_strap_pin_i,
    .avs_read_i, .avs_write_i, .avs_waitrequest_o, .chan_evt_i, .chan_cfg_o,
    .chan_ans_o, .error_out_n_o, .irq_o);
`default_nettype wire
